// ==== src/core_status_pkg.sv ====
// shared constants, encodings and state layouts for the core status bank
package core_status_pkg;

  // data address decode
  localparam int unsigned        ADDR_W          = 9;
  localparam int unsigned        BANK_LOW_W      = 7;
  localparam logic [6:0]         STATUS_LOW_ADDR = 7'h03;
  localparam logic [6:0]         INTCTL_LOW_ADDR = 7'h0B;
  localparam logic [8:0]         PIE_ADDR        = 9'h08C;

  // core_status field positions
  localparam int unsigned        ST_INDIRECT     = 7;
  localparam int unsigned        ST_DIRECT_HI    = 6;
  localparam int unsigned        ST_DIRECT_LO    = 5;
  localparam int unsigned        ST_TIMEOUT      = 4;
  localparam int unsigned        ST_POWERDOWN    = 3;
  localparam int unsigned        ST_ZERO         = 2;
  localparam int unsigned        ST_DIGIT_CARRY  = 1;
  localparam int unsigned        ST_CARRY        = 0;

  // interrupt_control field positions
  localparam int unsigned        IC_GLOBAL_EN    = 7;
  localparam int unsigned        IC_PERIPH_EN    = 6;
  localparam int unsigned        IC_TIMER0_EN    = 5;
  localparam int unsigned        IC_EXT_EN       = 4;
  localparam int unsigned        IC_PORT_EN      = 3;
  localparam int unsigned        IC_TIMER0_FLAG  = 2;
  localparam int unsigned        IC_EXT_FLAG     = 1;
  localparam int unsigned        IC_PORT_FLAG    = 0;

  // arithmetic widths
  localparam int unsigned        NIBBLE_W        = 4;
  localparam int unsigned        DATA_W          = 8;
  localparam int unsigned        MSB             = 7;
  localparam int unsigned        LSB             = 0;

  // reset values and write masks
  localparam logic [7:0]         STATUS_RESET    = 8'h18;
  localparam logic [7:0]         INTCTL_RESET    = 8'h00;
  localparam logic [7:0]         PIE_RESET       = 8'h00;
  localparam logic [7:0]         PIE_WR_MASK     = 8'hF7;
  localparam logic [7:0]         ZERO_BYTE       = 8'h00;

  // pin event detector
  localparam int unsigned        PIN_COUNT       = 5;
  localparam int unsigned        EXT_PIN_BIT     = 0;
  localparam logic [4:0]         PIN_RESET       = 5'h00;

  typedef enum logic [2:0] {
    OP_ADD       = 3'b000,
    OP_SUB       = 3'b001,
    OP_LOGIC     = 3'b010,
    OP_ROT_RIGHT = 3'b011,
    OP_ROT_LEFT  = 3'b100
  } alu_op_e;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] intctl;
    logic [7:0] pie;
    logic [7:0] rd_data;
    logic       irq;
  } bank_state_s;

  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] prev;
    logic       armed;
  } pin_state_s;

endpackage

// ==== src/pin_event_if.sv ====
// pin events passed from the pin detector to the register bank
`timescale 1ns/10ps
interface pin_event_if;
  logic ext_edge;
  logic port_change;

  modport source (
    output ext_edge,
    output port_change
  );

  modport sink (
    input ext_edge,
    input port_change
  );
endinterface

// ==== src/pin_event_detect.sv ====
// synchronises interrupt pins and detects their events
`timescale 1ns/10ps
module pin_event_detect (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       ext_interrupt_pin,
  input  wire logic [3:0] upper_port_pins,
  pin_event_if.source     events
);

  core_status_pkg::pin_state_s st;
  core_status_pkg::pin_state_s next_st;
  logic [4:0]                  raw;
  logic [4:0]                  changed;

  assign raw = {upper_port_pins, ext_interrupt_pin};

  genvar gi;
  generate
    for (gi = 0; gi < core_status_pkg::PIN_COUNT; gi++) begin : g_pin
      assign changed[gi] = st.armed & (st.sync2[gi] ^ st.prev[gi]);
    end
  endgenerate

  always_comb begin
    next_st       = st;
    next_st.sync1 = raw;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;
    next_st.armed = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st.sync1 <= core_status_pkg::PIN_RESET;
      st.sync2 <= core_status_pkg::PIN_RESET;
      st.prev  <= core_status_pkg::PIN_RESET;
      st.armed <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // rising edge on the external pin
  assign events.ext_edge =
    changed[core_status_pkg::EXT_PIN_BIT] &
    st.sync2[core_status_pkg::EXT_PIN_BIT];
  // any upper port pin toggled
  assign events.port_change = |changed[4:1];

endmodule

// ==== src/core_status_and_irq_control.sv ====
// core status, interrupt control and peripheral enable register bank
//
// What this block does
// - status writes by flag-changing ops keep the op's zero/digit/carry.
// - timeout and powerdown flags ignore every software write.
// - subtraction makes carry and digit carry active-low borrows.
// - indirect bank bit picks banks 2-3 when set, 0-1 when clear.
// - direct bank bits pick one of four 128-byte banks.
// - timeout flag set by power-up, watchdog clear, sleep; cleared on timeout.
// - powerdown flag set by power-up or watchdog clear; cleared by sleep.
// - zero flag follows whether the result is zero.
// - add/sub digit carry is the carry out of the low nibble.
// - add/sub carry is the carry out of the top result bit.
// - rotates load carry with the bit shifted out.
// - status answers at the same offset in all four banks.
// - source flags set regardless of any enable.
// - global enable passes unmasked interrupts, blocks all when clear.
// - peripheral enable passes unmasked peripheral interrupts.
// - timer0, external pin and port change enables gate their sources.
// - timer0 overflow sets its flag, held until software clears it.
// - external pin event sets its flag, held until software clears it.
// - any upper port pin change sets the port flag until cleared.
// - peripheral enables gate seven sources, bit 3 reads zero.
`timescale 1ns/10ps
module core_status_and_irq_control (
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  // file register port of the core
  input  wire logic [8:0]              reg_addr,
  input  wire logic                    reg_wr_en,
  input  wire logic [7:0]              reg_wr_data,
  input  wire logic                    reg_rd_en,
  output logic      [7:0]              reg_rd_data,
  // flag results from the executing instruction
  input  wire logic                    flag_update,
  input  wire core_status_pkg::alu_op_e flag_op,
  input  wire logic [7:0]              operand_a,
  input  wire logic [7:0]              operand_b,
  input  wire logic [7:0]              logic_result,
  // reset-cause events
  input  wire logic                    watchdog_clear_instr,
  input  wire logic                    sleep_instr,
  input  wire logic                    watchdog_timeout,
  // interrupt sources
  input  wire logic                    timer0_overflow,
  input  wire logic                    ext_interrupt_pin,
  input  wire logic [3:0]              upper_port_pins,
  input  wire logic [7:0]              peripheral_flags,
  // data address forming
  input  wire logic [6:0]              direct_addr_low,
  input  wire logic [7:0]              indirect_pointer,
  output logic      [8:0]              direct_data_addr,
  output logic      [8:0]              indirect_data_addr,
  output logic                         indirect_bank_bit,
  output logic      [1:0]              direct_bank_bits,
  output logic      [7:0]              status_out,
  output logic                         core_irq_request
);

  core_status_pkg::bank_state_s st;
  core_status_pkg::bank_state_s next_st;

  pin_event_if pin_events ();

  pin_event_detect u_pin_event_detect (
    .sys_clk           (sys_clk),
    .srst              (srst),
    .ext_interrupt_pin (ext_interrupt_pin),
    .upper_port_pins   (upper_port_pins),
    .events            (pin_events.source)
  );

  // address decode
  logic       hit_status;
  logic       hit_intctl;
  logic       hit_pie;
  logic       wr_status;
  logic       wr_intctl;
  logic       wr_pie;

  assign hit_status =
    (reg_addr[core_status_pkg::BANK_LOW_W-1:0] ==
     core_status_pkg::STATUS_LOW_ADDR);
  assign hit_intctl =
    (reg_addr[core_status_pkg::BANK_LOW_W-1:0] ==
     core_status_pkg::INTCTL_LOW_ADDR);
  assign hit_pie    = (reg_addr == core_status_pkg::PIE_ADDR);
  assign wr_status  = reg_wr_en & hit_status;
  assign wr_intctl  = reg_wr_en & hit_intctl;
  assign wr_pie     = reg_wr_en & hit_pie;

  // flag arithmetic
  logic       is_sub;
  logic [7:0] b_eff;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic       carry_in;
  logic       new_zero;
  logic       new_half;
  logic       new_carry;
  logic       upd_zero;
  logic       upd_half;
  logic       upd_carry;

  always_comb begin
    is_sub   = (flag_op == core_status_pkg::OP_SUB);
    // subtraction adds the two's complement of the second operand
    b_eff    = is_sub ? ~operand_b : operand_b;
    carry_in = is_sub;
    sum9     = {1'b0, operand_a} + {1'b0, b_eff} + {8'h00, carry_in};
    nib5     = {1'b0, operand_a[core_status_pkg::NIBBLE_W-1:0]} +
               {1'b0, b_eff[core_status_pkg::NIBBLE_W-1:0]} +
               {4'h0, carry_in};
    new_zero  = 1'b0;
    new_half  = 1'b0;
    new_carry = 1'b0;
    upd_zero  = 1'b0;
    upd_half  = 1'b0;
    upd_carry = 1'b0;
    case (flag_op)
      core_status_pkg::OP_ADD,
      core_status_pkg::OP_SUB: begin
        // no borrow leaves carry set, so polarity is reversed
        new_zero  = (sum9[core_status_pkg::MSB:0] ==
                     core_status_pkg::ZERO_BYTE);
        new_half  = nib5[core_status_pkg::NIBBLE_W];
        new_carry = sum9[core_status_pkg::DATA_W];
        upd_zero  = 1'b1;
        upd_half  = 1'b1;
        upd_carry = 1'b1;
      end
      core_status_pkg::OP_LOGIC: begin
        new_zero = (logic_result == core_status_pkg::ZERO_BYTE);
        upd_zero = 1'b1;
      end
      core_status_pkg::OP_ROT_RIGHT: begin
        new_carry = operand_a[core_status_pkg::LSB];
        upd_carry = 1'b1;
      end
      core_status_pkg::OP_ROT_LEFT: begin
        new_carry = operand_a[core_status_pkg::MSB];
        upd_carry = 1'b1;
      end
      default: begin
        upd_zero  = 1'b0;
      end
    endcase
  end

  // interrupt control and peripheral enables, next values
  logic [7:0] written_intctl;
  logic [7:0] next_intctl;
  logic [7:0] next_pie;
  logic [2:0] src_event;
  logic [2:0] src_flag;
  logic [2:0] src_enable;
  logic [2:0] src_pending;
  logic       core_pending;
  logic       periph_pending;
  logic       next_irq;

  // kept apart from next_st so the request logic forms no loop
  always_comb begin
    written_intctl = st.intctl;
    if (wr_intctl) begin
      written_intctl = reg_wr_data;
    end
  end

  // event order follows the flag order, port change in bit 0
  assign src_event = {timer0_overflow,
                      pin_events.ext_edge,
                      pin_events.port_change};

  // one flag and enable pair per core source; hardware set wins
  genvar si;
  generate
    for (si = 0; si < core_status_pkg::IC_PORT_EN; si++) begin : g_src
      assign src_flag[si] =
        written_intctl[core_status_pkg::IC_PORT_FLAG + si] |
        src_event[si];
      assign src_enable[si] =
        written_intctl[core_status_pkg::IC_PORT_EN + si];
      assign src_pending[si] = src_enable[si] & src_flag[si];
    end
  endgenerate

  assign next_intctl = {
    written_intctl[core_status_pkg::MSB:core_status_pkg::IC_PORT_EN],
    src_flag};

  // peripheral enables, unimplemented bit held at zero
  always_comb begin
    next_pie = st.pie;
    if (wr_pie) begin
      next_pie = reg_wr_data & core_status_pkg::PIE_WR_MASK;
    end
  end

  assign core_pending   = |src_pending;
  assign periph_pending =
    next_intctl[core_status_pkg::IC_PERIPH_EN] &
    (|(next_pie & peripheral_flags));
  assign next_irq =
    next_intctl[core_status_pkg::IC_GLOBAL_EN] &
    (core_pending | periph_pending);

  always_comb begin
    next_st = st;

    // status: bank bits from software
    if (wr_status) begin
      next_st.status[core_status_pkg::ST_INDIRECT] =
        reg_wr_data[core_status_pkg::ST_INDIRECT];
      next_st.status[core_status_pkg::ST_DIRECT_HI] =
        reg_wr_data[core_status_pkg::ST_DIRECT_HI];
      next_st.status[core_status_pkg::ST_DIRECT_LO] =
        reg_wr_data[core_status_pkg::ST_DIRECT_LO];
      // flag bits writable only when no flag update is under way, whichever flags the op owns
      if (!flag_update) begin
        next_st.status[core_status_pkg::ST_ZERO] =
          reg_wr_data[core_status_pkg::ST_ZERO];
        next_st.status[core_status_pkg::ST_DIGIT_CARRY] =
          reg_wr_data[core_status_pkg::ST_DIGIT_CARRY];
        next_st.status[core_status_pkg::ST_CARRY] =
          reg_wr_data[core_status_pkg::ST_CARRY];
      end
    end

    // op result overrides, even on a write to status
    if (flag_update) begin
      if (upd_zero) begin
        next_st.status[core_status_pkg::ST_ZERO] = new_zero;
      end
      if (upd_half) begin
        next_st.status[core_status_pkg::ST_DIGIT_CARRY] = new_half;
      end
      if (upd_carry) begin
        next_st.status[core_status_pkg::ST_CARRY] = new_carry;
      end
    end

    // reset-cause flags, hardware only; timeout wins
    if (watchdog_clear_instr) begin
      next_st.status[core_status_pkg::ST_TIMEOUT]   = 1'b1;
      next_st.status[core_status_pkg::ST_POWERDOWN] = 1'b1;
    end
    if (sleep_instr) begin
      next_st.status[core_status_pkg::ST_TIMEOUT]   = 1'b1;
      next_st.status[core_status_pkg::ST_POWERDOWN] = 1'b0;
    end
    if (watchdog_timeout) begin
      next_st.status[core_status_pkg::ST_TIMEOUT] = 1'b0;
    end

    // interrupt registers take the values formed above
    next_st.intctl = next_intctl;
    next_st.pie    = next_pie;

    // registered read data, unmapped reads zero
    if (reg_rd_en) begin
      if (hit_status) begin
        next_st.rd_data = st.status;
      end else if (hit_intctl) begin
        next_st.rd_data = st.intctl;
      end else if (hit_pie) begin
        next_st.rd_data = st.pie;
      end else begin
        next_st.rd_data = core_status_pkg::ZERO_BYTE;
      end
    end

    next_st.irq = next_irq;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st.status  <= core_status_pkg::STATUS_RESET;
      st.intctl  <= core_status_pkg::INTCTL_RESET;
      st.pie     <= core_status_pkg::PIE_RESET;
      st.rd_data <= core_status_pkg::ZERO_BYTE;
      st.irq     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rd_data       = st.rd_data;
  assign status_out        = st.status;
  assign core_irq_request  = st.irq;
  assign indirect_bank_bit = st.status[core_status_pkg::ST_INDIRECT];
  assign direct_bank_bits  =
    st.status[core_status_pkg::ST_DIRECT_HI:core_status_pkg::ST_DIRECT_LO];

  // bank bits form the top of the data address
  assign direct_data_addr   = {direct_bank_bits, direct_addr_low};
  assign indirect_data_addr = {indirect_bank_bit, indirect_pointer};

endmodule

// ==== test/core_status_properties.sv ====
// port assertions for the core status bank
`timescale 1ns/10ps
module core_status_checker (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic [8:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic       flag_update,
  input wire core_status_pkg::alu_op_e flag_op,
  input wire logic [7:0] operand_a,
  input wire logic [7:0] operand_b,
  input wire logic       watchdog_clear_instr,
  input wire logic       sleep_instr,
  input wire logic       watchdog_timeout,
  input wire logic [7:0] status_out,
  input wire logic       core_irq_request
);
  logic [8:0] add9, sub9;
  logic [4:0] addn, subn;
  logic [2:0] add_f, sub_f;
  logic       global_en;
  assign add9  = {1'b0, operand_a} + {1'b0, operand_b};
  assign sub9  = {1'b0, operand_a} + {1'b0, ~operand_b} + 9'h001;
  assign addn  = {1'b0, operand_a[3:0]} + {1'b0, operand_b[3:0]};
  assign subn  = {1'b0, operand_a[3:0]} + {1'b0, ~operand_b[3:0]} + 5'h01;
  assign add_f = {add9[7:0] == 8'h00, addn[4], add9[8]};
  assign sub_f = {sub9[7:0] == 8'h00, subn[4], sub9[8]};
  // shadow of the global enable, only software changes it
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      global_en <= 1'b0;
    end else if (reg_wr_en && reg_addr[6:0] == 7'h0B) begin
      global_en <= reg_wr_data[7];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence st_wr;
    reg_wr_en && reg_addr[6:0] == 7'h03;
  endsequence
  sequence no_cause;
    !watchdog_clear_instr && !sleep_instr && !watchdog_timeout;
  endsequence
  sequence op_is(core_status_pkg::alu_op_e o);
    flag_update && flag_op == o;
  endsequence
  ro_flags_a: assert property (st_wr ##0 no_cause |=>
    $stable(status_out[4:3])) else $error("write moved cause bits");
  bank_write_a: assert property (st_wr ##0 !flag_update |=>
    {status_out[7:5], status_out[2:0]} == $past({reg_wr_data[7:5],
    reg_wr_data[2:0]})) else $error("status write lost");
  sleep_cause_a: assert property (sleep_instr && !watchdog_timeout &&
    !watchdog_clear_instr |=> status_out[4:3] == 2'h2)
    else $error("sleep cause bits wrong");
  clear_cause_a: assert property (watchdog_clear_instr && !sleep_instr &&
    !watchdog_timeout |=> status_out[4:3] == 2'h3)
    else $error("watchdog clear cause bits wrong");
  timeout_cause_a: assert property (watchdog_timeout |=> !status_out[4])
    else $error("timeout flag not cleared");
  add_flags_a: assert property (op_is(core_status_pkg::OP_ADD) |=>
    status_out[2:0] == $past(add_f)) else $error("add flags wrong");
  sub_flags_a: assert property (op_is(core_status_pkg::OP_SUB) |=>
    status_out[2:0] == $past(sub_f)) else $error("sub flags wrong");
  rot_right_a: assert property (op_is(core_status_pkg::OP_ROT_RIGHT)
    |=> status_out[0] == $past(operand_a[0])) else $error("rrot carry");
  rot_left_a: assert property (op_is(core_status_pkg::OP_ROT_LEFT)
    |=> status_out[0] == $past(operand_a[7])) else $error("lrot carry");
  global_block_a: assert property (!global_en |-> !core_irq_request)
    else $error("request while global enable clear");
endmodule
bind core_status_and_irq_control core_status_checker core_status_checker_i (
  .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .flag_update(flag_update), .flag_op(flag_op),
  .operand_a(operand_a), .operand_b(operand_b),
  .watchdog_clear_instr(watchdog_clear_instr), .sleep_instr(sleep_instr),
  .watchdog_timeout(watchdog_timeout), .status_out(status_out),
  .core_irq_request(core_irq_request)
);

// ==== test/irq_source_model.sv ====
// interrupt source model: timer0, external pin and port pins
`timescale 1ns/10ps
module irq_source_model (
  input  wire logic       sys_clk,
  input  wire logic [2:0] fire,
  output logic            timer0_overflow,
  output logic            ext_interrupt_pin,
  output logic      [3:0] upper_port_pins
);
  initial begin
    timer0_overflow = 1'b0;
    ext_interrupt_pin = 1'b0;
    upper_port_pins = 4'h0;
  end
  always @(posedge sys_clk) begin
    timer0_overflow <= fire[0];
    if (fire[1]) begin
      ext_interrupt_pin <= ~ext_interrupt_pin;
    end
    if (fire[2]) begin
      upper_port_pins <= upper_port_pins + 4'h1;
    end
  end
endmodule

// ==== test/core_status_and_irq_control_test.sv ====
// self-checking bench for the core status bank
`timescale 1ns/10ps
module core_status_and_irq_control_test;
  logic       sys_clk, srst, reg_wr_en, reg_rd_en, flag_update;
  logic       watchdog_clear_instr, sleep_instr, watchdog_timeout;
  logic       timer0_overflow, ext_interrupt_pin, indirect_bank_bit;
  logic       core_irq_request;
  logic [8:0] reg_addr, direct_data_addr, indirect_data_addr, s;
  logic [7:0] reg_wr_data, reg_rd_data, operand_a, operand_b, d, e;
  logic [7:0] logic_result, peripheral_flags, indirect_pointer, status_out;
  logic [6:0] direct_addr_low;
  logic [3:0] upper_port_pins;
  logic [2:0] fire, f;
  logic [1:0] direct_bank_bits;
  int         fails = 0, check_count = 0;
  core_status_pkg::alu_op_e flag_op;
  logic [7:0] ta [6] = '{8'h0F, 8'hFF, 8'h10, 8'h05, 8'h03, 8'h10};
  logic [7:0] tv [6] = '{8'h01, 8'h01, 8'h20, 8'h05, 8'h05, 8'h01};
  logic [7:0] ic [7] = '{8'h00, 8'hA0, 8'h80, 8'h90, 8'h88, 8'h08, 8'h90};
  logic [7:0] xc [7] = '{8'h04, 8'hA4, 8'h84, 8'h92, 8'h89, 8'h09, 8'h90};
  logic [2:0] fv [7] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h4, 3'h4, 3'h2};
  logic [2:0] cv [4] = '{3'h2, 3'h4, 3'h1, 3'h4};
  logic [1:0] ce [4] = '{2'h2, 2'h3, 2'h1, 2'h3};
  logic [6:0] xi = 7'h1A;

  core_status_and_irq_control core_status_and_irq_control_i (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .flag_update(flag_update), .flag_op(flag_op), .operand_a(operand_a),
    .operand_b(operand_b), .logic_result(logic_result),
    .watchdog_clear_instr(watchdog_clear_instr), .sleep_instr(sleep_instr),
    .watchdog_timeout(watchdog_timeout), .timer0_overflow(timer0_overflow),
    .ext_interrupt_pin(ext_interrupt_pin),
    .upper_port_pins(upper_port_pins), .peripheral_flags(peripheral_flags),
    .direct_addr_low(direct_addr_low), .indirect_pointer(indirect_pointer),
    .direct_data_addr(direct_data_addr),
    .indirect_data_addr(indirect_data_addr),
    .indirect_bank_bit(indirect_bank_bit),
    .direct_bank_bits(direct_bank_bits), .status_out(status_out),
    .core_irq_request(core_irq_request)
  );
  irq_source_model irq_source_model_i (
    .sys_clk(sys_clk), .fire(fire), .timer0_overflow(timer0_overflow),
    .ext_interrupt_pin(ext_interrupt_pin),
    .upper_port_pins(upper_port_pins)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wr_data = v;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    // idle edge keeps back-to-back writes apart
    @(negedge sys_clk);
  endtask

  // data registered at the read edge, taken a cycle later
  task automatic rd(input logic [8:0] a, output logic [7:0] r);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    @(negedge sys_clk);
    r = reg_rd_data;
  endtask

  task automatic fchk(input logic [2:0] o, input logic [7:0] a, b,
                      input logic [2:0] m, x);
    logic [7:0] r;
    flag_op = core_status_pkg::alu_op_e'(o);
    operand_a = a;
    operand_b = b;
    logic_result = a;
    flag_update = 1'b1;
    @(negedge sys_clk);
    flag_update = 1'b0;
    reg_wr_en = 1'b0;
    rd(9'h183, r);
    chk(r[2:0] & m, x);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge sys_clk);
    fails++;
    tally_and_finish();
  end

  initial begin
    srst = 1'b1;
    {reg_wr_en, reg_rd_en, flag_update, fire} = 6'h00;
    {watchdog_clear_instr, sleep_instr, watchdog_timeout} = 3'h0;
    {reg_addr, reg_wr_data, operand_a, operand_b} = 33'h0;
    {logic_result, peripheral_flags} = 16'h0000;
    indirect_pointer = 8'hA3;
    direct_addr_low = 7'h55;
    flag_op = core_status_pkg::OP_ADD;
    repeat (3) @(negedge sys_clk);
    srst = 1'b0;
    rd(9'h003, d);
    chk(d, 8'h18);
    rd(9'h08B, d);
    chk(d, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = {i[0], i[1:0], 5'h05};
      wr({i[1:0], 7'h03}, d);
      rd({i[1:0] + 2'h1, 7'h03}, e);
      chk(e, d | 8'h18);
      chk({direct_data_addr, indirect_data_addr, indirect_bank_bit,
           direct_bank_bits}, {i[1:0], 7'h55, i[0], 8'hA3, i[0],
           i[1:0]});
    end
    for (int i = 0; i < 6; i++) begin
      d = ta[i];
      e = tv[i];
      s = (i < 3) ? {1'b0, d} + {1'b0, e} : {1'b0, d} - {1'b0, e};
      f[2] = s[7:0] == 8'h00;
      f[1] = (i < 3) ? 5'(d[3:0]) + 5'(e[3:0]) > 5'h0F : d[3:0] >= e[3:0];
      f[0] = (i < 3) ? s[8] : d >= e;
      fchk((i < 3) ? 3'h0 : 3'h1, d, e, 3'h7, f);
    end
    fchk(3'h3, 8'h01, 8'h00, 3'h1, 3'h1);
    fchk(3'h4, 8'h01, 8'h00, 3'h1, 3'h0);
    fchk(3'h4, 8'h80, 8'h00, 3'h1, 3'h1);
    fchk(3'h2, 8'h00, 8'h00, 3'h4, 3'h4);
    fchk(3'h2, 8'h10, 8'h00, 3'h4, 3'h0);
    reg_addr = 9'h103;
    reg_wr_data = 8'h00;
    reg_wr_en = 1'b1;
    fchk(3'h0, 8'hFF, 8'h01, 3'h7, 3'h7);
    chk(status_out[7:5], 3'h0);
    for (int i = 0; i < 4; i++) begin
      {watchdog_clear_instr, sleep_instr, watchdog_timeout} = cv[i];
      @(negedge sys_clk);
      {watchdog_clear_instr, sleep_instr, watchdog_timeout} = 3'h0;
      rd(9'h003, d);
      chk(d[4:3], ce[i]);
    end
    for (int i = 0; i < 7; i++) begin
      wr({i[1:0], 7'h0B}, ic[i]);
      fire = fv[i];
      @(negedge sys_clk);
      fire = 3'h0;
      repeat (6) @(negedge sys_clk);
      rd(9'h00B, d);
      chk(d, xc[i]);
      chk(core_irq_request, xi[i]);
    end
    wr(9'h08C, 8'hFF);
    rd(9'h08C, d);
    chk(d, 8'hF7);
    peripheral_flags = 8'h08;
    wr(9'h00B, 8'hC0);
    chk(core_irq_request, 1'b0);
    peripheral_flags = 8'h01;
    wr(9'h00B, 8'h80);
    chk(core_irq_request, 1'b0);
    wr(9'h00B, 8'hC0);
    chk(core_irq_request, 1'b1);
    wr(9'h08C, 8'h00);
    chk(core_irq_request, 1'b0);
    wr(9'h10C, 8'hFF);
    rd(9'h10C, d);
    chk(d, 8'h00);
    tally_and_finish();
  end
endmodule
